// ---- rtl/scrs_pkg.sv ----
/*
  Constants and carrier types for the calibration register sequencer.
  Assumes a single 25 MHz system clock and active-low async reset.
*/
package scrs_pkg;
  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int WORD_W = 32;
  localparam int SEL_W = 4;
  localparam logic [3:0] SEL_R0 = 4'h0;
  localparam logic [3:0] SEL_R1 = 4'h1;
  localparam logic [3:0] SEL_R2 = 4'h2;
  localparam logic [3:0] SEL_R8 = 4'h8;
  localparam logic [3:0] SEL_CALIB = 4'h9;
  localparam logic [3:0] SEL_TEMP = 4'hA;
  localparam logic [3:0] SEL_HOLD = 4'hB;
  localparam logic [3:0] SEL_RESYNC = 4'hC;
  localparam logic [3:0] SEL_AUX = 4'hD;
  localparam logic [31:0] FIXED_WORD = 32'h15596568;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BAND_DIV_LSB = 24;
  localparam int TIMEOUT_LSB = 14;
  localparam int ALC_LSB = 9;
  localparam int SETTLE_LSB = 4;
  localparam int ADC_DIV_LSB = 6;
  localparam int CONV_ON_WR_BIT = 5;
  localparam int ADC_PWR_BIT = 4;
  localparam int HOLD_BIT = 24;
  localparam int RESYNC_LSB = 12;
  localparam int AUX_FRAC_LSB = 18;
  localparam int AUX_MOD_LSB = 4;
  localparam int AUX_SHIFT = 14;
  localparam int PART_W = 14;
  localparam int AUX_W = 28;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int ADC_WAIT_CYC = 16;
  localparam logic [31:0] WORD_RST = 32'h00000000;
  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] band_division_value;
    logic [9:0] band_select_timeout;
    logic [4:0] level_cal_wait;
    logic [4:0] lock_settle_timeout;
  } scrs_calib_t;
  typedef struct packed {
    logic [27:0] aux_fraction;
    logic [27:0] aux_modulus;
    logic [23:0] main_fraction;
    logic [27:0] main_integer;
  } scrs_freq_t;
endpackage

// ---- rtl/scrs_div.sv ----
/*
  Programmable divider producing one-cycle enable pulses.
  Assumes the source enable is on the same clock; divide 0 acts as 1.
*/
`timescale 1ns/100ps
module scrs_div #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic src_en,
  input wire logic [W-1:0] div,
  // Result
  output logic tick
);
  if (W < 1) begin : g_bad_width
    $error("scrs_div width must be positive");
  end
  logic [W-1:0] cnt_r;
  wire last = (cnt_r + W'(1) >= div);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      tick <= src_en && last;
      if (src_en) cnt_r <= last ? '0 : cnt_r + W'(1);
    end
  end
endmodule

// ---- rtl/scrs_seq.sv ----
/*
  Serial word receiver and configuration registers 9..13 with
  frequency apply on register 0, converter clock and wait counter.
  Assumes a three-wire host (data, clock, load) slower than clk and a
  PFD reference pulse supplied as an input pin.
*/
`timescale 1ns/100ps
module scrs_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial programming pins
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load,
  // Reference and analog-side events
  input wire logic pfd_ref,
  input wire logic counter_reset,
  // Configuration outputs
  output scrs_pkg::scrs_calib_t calib,
  output logic [7:0] adc_clk_div,
  output logic adc_power_on,
  output logic adc_tick,
  output logic adc_start,
  output logic adc_ready,
  output logic vco_band_hold,
  output logic vco_state_reset,
  output logic [19:0] resync_count,
  output scrs_pkg::scrs_freq_t freq,
  output logic freq_update,
  output logic fixed_word_bad
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] sck_s, sdi_s, sle_s, ref_s;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_s <= 3'h0;
      sdi_s <= 3'h0;
      sle_s <= 3'h0;
      ref_s <= 3'h0;
    end else begin
      sck_s <= {sck_s[1:0], ser_clk};
      sdi_s <= {sdi_s[1:0], ser_data};
      sle_s <= {sle_s[1:0], ser_load};
      ref_s <= {ref_s[1:0], pfd_ref};
    end
  end
  logic sck_q, sle_q, ref_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
      sle_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      if (sck_s[1] == sck_s[2]) sck_q <= sck_s[2];
      if (sle_s[1] == sle_s[2]) sle_q <= sle_s[2];
      if (ref_s[1] == ref_s[2]) ref_q <= ref_s[2];
    end
  end
  wire sck_rise = (sck_s[1] == sck_s[2]) && sck_s[2] && !sck_q;
  wire sle_rise = (sle_s[1] == sle_s[2]) && sle_s[2] && !sle_q;
  wire ref_rise = (ref_s[1] == ref_s[2]) && ref_s[2] && !ref_q;
  // ****************************************************************
  // Shift register, MSB first
  // ****************************************************************
  logic [31:0] shift_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) shift_r <= scrs_pkg::WORD_RST;
    else if (sck_rise) shift_r <= {shift_r[30:0], sdi_s[2]};
  end
  wire [3:0] register_select_bits = shift_r[3:0];
  wire wr_calib = sle_rise && (register_select_bits == scrs_pkg::SEL_CALIB);
  wire wr_temp = sle_rise && (register_select_bits == scrs_pkg::SEL_TEMP);
  wire wr_hold = sle_rise && (register_select_bits == scrs_pkg::SEL_HOLD);
  wire wr_resync = sle_rise && (register_select_bits == scrs_pkg::SEL_RESYNC);
  wire wr_aux = sle_rise && (register_select_bits == scrs_pkg::SEL_AUX);
  wire wr_r8 = sle_rise && (register_select_bits == scrs_pkg::SEL_R8);
  wire wr_r2 = sle_rise && (register_select_bits == scrs_pkg::SEL_R2);
  wire wr_r1 = sle_rise && (register_select_bits == scrs_pkg::SEL_R1);
  wire wr_r0 = sle_rise && (register_select_bits == scrs_pkg::SEL_R0);
  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [31:0] calib_timing_config_r, temp_converter_config_r, vco_hold_config_r;
  logic [31:0] phase_resync_config_r, aux_fraction_upper_r, low2_r, low1_r;
  logic [31:0] pend_r0_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calib_timing_config_r <= scrs_pkg::WORD_RST;
      temp_converter_config_r <= scrs_pkg::WORD_RST;
      vco_hold_config_r <= scrs_pkg::WORD_RST;
      phase_resync_config_r <= scrs_pkg::WORD_RST;
      aux_fraction_upper_r <= scrs_pkg::WORD_RST;
      low2_r <= scrs_pkg::WORD_RST;
      low1_r <= scrs_pkg::WORD_RST;
      pend_r0_r <= scrs_pkg::WORD_RST;
      fixed_word_bad <= 1'b0;
    end else begin
      if (wr_calib) calib_timing_config_r <= shift_r;
      if (wr_temp) temp_converter_config_r <= shift_r;
      if (wr_hold) vco_hold_config_r <= shift_r;
      if (wr_resync) phase_resync_config_r <= shift_r;
      if (wr_aux) aux_fraction_upper_r <= shift_r;
      if (wr_r2) low2_r <= shift_r;
      if (wr_r1) low1_r <= shift_r;
      if (wr_r0) pend_r0_r <= shift_r;
      if (wr_r8) fixed_word_bad <= (shift_r != scrs_pkg::FIXED_WORD);
    end
  end
  // ****************************************************************
  // Field decode
  // ****************************************************************
  assign calib.band_division_value = calib_timing_config_r[scrs_pkg::BAND_DIV_LSB +: 8];
  assign calib.band_select_timeout = calib_timing_config_r[scrs_pkg::TIMEOUT_LSB +: 10];
  assign calib.level_cal_wait = calib_timing_config_r[scrs_pkg::ALC_LSB +: 5];
  assign calib.lock_settle_timeout = calib_timing_config_r[scrs_pkg::SETTLE_LSB +: 5];
  assign adc_clk_div = temp_converter_config_r[scrs_pkg::ADC_DIV_LSB +: 8];
  wire convert_on_write = temp_converter_config_r[scrs_pkg::CONV_ON_WR_BIT];
  assign adc_power_on = temp_converter_config_r[scrs_pkg::ADC_PWR_BIT];
  assign vco_band_hold = vco_hold_config_r[scrs_pkg::HOLD_BIT];
  assign resync_count = phase_resync_config_r[scrs_pkg::RESYNC_LSB +: 20];
  assign vco_state_reset = counter_reset && !vco_band_hold;
  // ****************************************************************
  // Converter clock and measurement start
  // ****************************************************************
  scrs_div #(.W(8)) u_adc_div (
    .clk(clk),
    .rst_n(rst_n),
    .src_en(ref_rise),
    .div(adc_clk_div),
    .tick(adc_tick)
  );
  logic start_pend_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_start <= 1'b0;
      start_pend_r <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      if (wr_temp) start_pend_r <= shift_r[scrs_pkg::CONV_ON_WR_BIT];
      else if (start_pend_r && adc_tick && adc_power_on) begin
        adc_start <= 1'b1;
        start_pend_r <= 1'b0;
      end
    end
  end
  // Status: converter clocks seen since last register 10 write
  logic [4:0] adc_cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) adc_cnt_r <= 5'h00;
    else if (wr_temp) adc_cnt_r <= 5'h00;
    else if (adc_tick && adc_cnt_r <= 5'(scrs_pkg::ADC_WAIT_CYC)) adc_cnt_r <= adc_cnt_r + 5'h01;
  end
  assign adc_ready = (adc_cnt_r > 5'(scrs_pkg::ADC_WAIT_CYC));
  // ****************************************************************
  // Frequency apply on register 0
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freq <= '0;
      freq_update <= 1'b0;
    end else begin
      freq_update <= wr_r0;
      if (wr_r0) begin
        freq.aux_fraction <= (28'(aux_fraction_upper_r[scrs_pkg::AUX_FRAC_LSB +: 14])
          << scrs_pkg::AUX_SHIFT) + 28'(low2_r[scrs_pkg::AUX_FRAC_LSB +: 14]);
        freq.aux_modulus <= (28'(aux_fraction_upper_r[scrs_pkg::AUX_MOD_LSB +: 14])
          << scrs_pkg::AUX_SHIFT) + 28'(low2_r[scrs_pkg::AUX_MOD_LSB +: 14]);
        freq.main_fraction <= low1_r[27:4];
        freq.main_integer <= 28'(shift_r[31:4]);
      end
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_load_calib: assert property (@(posedge clk) disable iff (!rst_n)
    wr_calib |=> calib_timing_config_r == $past(shift_r))
    else $error("register 9 not loaded");
  a_load_aux: assert property (@(posedge clk) disable iff (!rst_n)
    wr_aux |=> aux_fraction_upper_r == $past(shift_r))
    else $error("register 13 not loaded");
  a_freq_only_r0: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_r0 |=> $stable(freq))
    else $error("frequency changed without register 0");
  a_keep_other: assert property (@(posedge clk) disable iff (!rst_n)
    (sle_rise && !wr_hold) |=> $stable(vco_hold_config_r))
    else $error("unselected register changed");
  a_hold_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    vco_band_hold |-> !vco_state_reset)
    else $error("VCO reset despite hold");
  a_start_power: assert property (@(posedge clk) disable iff (!rst_n)
    adc_start |-> adc_power_on && convert_on_write && $past(adc_tick))
    else $error("measurement start without clock or power");
  a_ready_clear: assert property (@(posedge clk) disable iff (!rst_n)
    wr_temp |=> !adc_ready)
    else $error("ready not cleared by register 10 write");
  a_fixed_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_r8 && shift_r == scrs_pkg::FIXED_WORD) |=> !fixed_word_bad)
    else $error("fixed word flagged wrongly");
endmodule

// ---- tb/scrs_host.sv ----
/*
  Host model driving the three-wire programming pins.
  Assumes clk is the design clock; ser_clk idles low between words.
*/
`timescale 1ns/100ps
module scrs_host (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic ser_clk,
  output logic ser_data,
  output logic ser_load
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b1;
    ser_load = 1'b0;
  end
  // Whole word, top bit first, then the load strobe
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk) ser_data <= w[i];
      repeat (4) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge clk);
      ser_clk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    ser_load <= 1'b1;
    ser_data <= ~w[0];
    repeat (4) @(posedge clk);
    ser_load <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ---- tb/synth_calib_register_sequencer_tb.sv ----
/*
  Self-checking bench for the calibration register sequencer.
  Assumes the package, design and host model are compiled before it.
*/
`timescale 1ns/100ps
module synth_calib_register_sequencer_tb;
  typedef struct packed {
    logic [31:0] word;
    logic bad;
  } scrs_row_t;
  logic clk, rst_n, pfd_ref, counter_reset, ser_clk, ser_data, ser_load, load_q;
  logic adc_power_on, adc_tick, adc_start, adc_ready, vco_band_hold, vco_state_reset;
  logic freq_update, fixed_word_bad;
  logic [7:0] adc_clk_div;
  logic [19:0] resync_count;
  logic rdy_q, ref_ph;
  logic [3:0] cur_sel;
  logic [31:0] ex [16];
  scrs_pkg::scrs_calib_t calib;
  scrs_pkg::scrs_freq_t freq;
  int failures, n_checks, n_tick, n_start, n_upd, k, tick_at_rdy;
  scrs_row_t rows [12] = '{
    '{32'hFFFFFFFE, 1'b0},
    '{32'hABCDE12D, 1'b0},
    '{32'hFFFFF5FC, 1'b0},
    '{32'h0161200B, 1'b0},
    '{32'h00C000BA, 1'b0},
    '{32'h2719FCC9, 1'b0},
    '{32'h15596568, 1'b0},
    '{32'h15596578, 1'b1},
    '{32'h15596568, 1'b0},
    '{32'hFFFFFFF3, 1'b0},
    '{32'h12345672, 1'b0},
    '{32'h0ABCDEF1, 1'b0}
  };
  scrs_host i_host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_load(ser_load));
  scrs_seq i_dut (.clk(clk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_load(ser_load), .pfd_ref(pfd_ref), .counter_reset(counter_reset), .calib(calib),
    .adc_clk_div(adc_clk_div), .adc_power_on(adc_power_on), .adc_tick(adc_tick),
    .adc_start(adc_start), .adc_ready(adc_ready), .vco_band_hold(vco_band_hold),
    .vco_state_reset(vco_state_reset), .resync_count(resync_count), .freq(freq),
    .freq_update(freq_update), .fixed_word_bad(fixed_word_bad));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Reference edge every fourth cycle, so the pin filter sees each level twice
  always @(posedge clk) begin
    ref_ph <= ~ref_ph;
    if (ref_ph) pfd_ref <= ~pfd_ref;
    load_q <= ser_load;
    rdy_q <= adc_ready;
    if (adc_ready && !rdy_q) tick_at_rdy <= n_tick;
    n_tick <= (ser_load && !load_q && cur_sel == scrs_pkg::SEL_TEMP) ? 0
      : n_tick + int'(adc_tick);
    n_start <= n_start + int'(adc_start);
    n_upd <= n_upd + int'(freq_update);
  end
  // ****************************************************************
  // Checking
  // ****************************************************************
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic put(input logic [31:0] w);
    cur_sel = w[3:0];
    i_host.send(w);
    if (w[3:0] < 4'h3 || (w[3:0] > 4'h8 && w[3:0] < 4'hE)) begin
      ex[w[3:0]] = w;
    end
  endtask
  task automatic cmp_regs();
    chk(calib, ex[9][31:4]);
    chk(calib.band_select_timeout, ex[9][23:14]);
    chk(adc_clk_div, ex[10][13:6]);
    chk(adc_power_on, ex[10][4]);
    chk(vco_band_hold, ex[11][24]);
    chk(resync_count, ex[12][31:12]);
  endtask
  // Upper part above a 14-bit lower part, so shift plus add is a concatenation
  function automatic logic [107:0] exp_freq();
    return {ex[13][31:18], ex[2][31:18], ex[13][17:4], ex[2][17:4], ex[1][27:4], ex[0][31:4]};
  endfunction
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    pfd_ref = 1'b0;
    counter_reset = 1'b0;
    load_q = 1'b0;
    failures = 0;
    n_checks = 0;
    n_tick = 0;
    n_start = 0;
    n_upd = 0;
    tick_at_rdy = 0;
    rdy_q = 1'b0;
    ref_ph = 1'b0;
    cur_sel = 4'h0;
    foreach (ex[i]) ex[i] = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      put(rows[i].word);
      cmp_regs();
      chk(fixed_word_bad, rows[i].bad);
    end
    begin : seq_body
      // Frequency change: 13, 10, 2, 1, wait, 0
      put(32'h5555AAAD);
      k = n_start;
      put(32'h00C000BA);
      chk(adc_ready, 1'b0);
      put(32'h2468ACE2);
      put(32'h01357991);
      for (int i = 0; i < 400 && adc_ready !== 1'b1; i++) begin
        @(posedge clk);
      end
      if (adc_ready !== 1'b1) begin
        failures++;
        disable seq_body;
      end
      chk(tick_at_rdy > 16 && tick_at_rdy < 20, 1'b1);
      chk(n_start - k, 1);
      chk(n_upd, 0);
      put(32'h00000440);
      chk(n_upd, 1);
      chk(freq, exp_freq());
      // Second step of the fast-reference start: 13, 4, 2, 1, 0
      put(32'h1234400D);
      put(32'h30008B84);
      put(32'h0AF0C002);
      put(32'h0C6A7E51);
      cmp_regs();
      put(32'h00000220);
      chk(n_upd, 2);
      chk(freq, exp_freq());
      for (int i = 0; i < 2; i++) begin
        k = n_start;
        put(i == 0 ? 32'h00C0009A : 32'h00C000AA);
        repeat (80) @(posedge clk);
        chk(n_start - k, 0);
        cmp_regs();
      end
      counter_reset <= 1'b1;
      @(posedge clk);
      chk(vco_state_reset, 1'b0);
      put(32'h0061200B);
      chk(vco_state_reset, 1'b1);
      counter_reset <= 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk(freq, 0);
      chk(calib, 0);
      chk(adc_ready, 1'b0);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk(fixed_word_bad, 1'b0);
    end
    tally_and_finish();
  end
endmodule
